/* rtl/plr_restart.v */
// Added by the designer: the placing of the registers and the plain strobed port.
`include "plr_defs.vh"
`default_nettype none
module plr_restart #(
  parameter SPD_W = 16,                       // speed word width
  parameter SEC_CYCLES = `PLR_SEC_CYCLES,     // cycles per second
  parameter SETTLE_CYCLES = `PLR_SETTLE_CYCLES // clean-run time before retry count clears
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [`PLR_ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_undervoltage,                  // dc link below undervoltage level
  input wire i_ctrl_power_lost,               // control supply dropped during failure
  input wire i_overvoltage_alarm,
  input wire i_drive_overheat_alarm,
  input wire i_board_overheat_alarm,
  input wire i_drive_overload_alarm,
  input wire i_motor_overload_alarm,
  input wire i_other_fault,                   // any non-eligible fault
  input wire i_forward_run_cmd,
  input wire i_reverse_run_cmd,
  input wire i_keypad_stop,                   // keypad stop key
  input wire i_run_hold_input,
  input wire i_adjuster_increase_cmd,
  input wire i_adjuster_decrease_cmd,
  input wire i_adjuster_clear_cmd,
  input wire [SPD_W-1:0] i_motor_speed,       // measured speed
  input wire [SPD_W-1:0] i_speed_setting,     // ramp-mode speed setting
  input wire [SPD_W-1:0] i_adjuster_speed,    // adjuster output
  output reg o_output_enable,                 // power stage gating
  output reg [SPD_W-1:0] o_speed_cmd,
  output reg [SPD_W-1:0] o_ramp_rate,         // per-step rate of recovery ramp
  output reg o_decel_stop,                    // decelerate-to-stop request
  output reg o_adjuster_enable,               // adjuster commands passed through
  output reg o_adjuster_increase,
  output reg o_adjuster_decrease,
  output reg o_adjuster_clear,
  output reg o_undervoltage_alarm,
  output reg o_any_alarm,
  output reg o_link_voltage_ok_flag,
  output reg o_protect_clear,                 // one-cycle protection release
  output wire o_irq
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [6:0] ST_RUN = 7'h01;
  localparam [6:0] ST_COAST = 7'h02;
  localparam [6:0] ST_RAMP = 7'h04;
  localparam [6:0] ST_STOP = 7'h08;
  localparam [6:0] ST_WAIT = 7'h10;
  localparam [6:0] ST_ALARM = 7'h20;
  localparam [6:0] ST_LOCK = 7'h40;           // stopped until fresh run

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [31:0] ctrl_r;                          // software control word
  reg [`PLR_EV_W-1:0] irq_stat_r;             // sticky events
  reg [`PLR_EV_W-1:0] irq_mask_r;             // event enables
  reg [6:0] state_r;
  reg [SPD_W-1:0] held_speed_r;               // speed before failure
  reg [2:0] retry_cnt_r;                      // retries consumed
  reg [4:0] sec_cnt_r;                        // seconds waited
  reg [31:0] tick_cnt_r;                      // cycles within a second
  reg [31:0] settle_cnt_r;                    // clean-run cycles
  reg stop_seen_r;                            // keypad stop during failure
  reg hold_drop_r;                            // run-hold dropped during failure
  reg run_drop_r;                             // both run commands off in failure
  reg [`PLR_EV_W-1:0] ev;                     // this cycle's events

  wire restart_en = ctrl_r[`PLR_CTRL_RESTART_BIT];
  wire adj_mode = ctrl_r[`PLR_CTRL_ADJ_MODE_BIT];
  wire keypad_mode = ctrl_r[`PLR_CTRL_KEYPAD_BIT];
  wire hold_mode = ctrl_r[`PLR_CTRL_HOLD_BIT];
  wire [2:0] retry_lim = ctrl_r[`PLR_CTRL_RCNT_MSB:`PLR_CTRL_RCNT_LSB];
  wire [4:0] ivl_raw = ctrl_r[`PLR_CTRL_IVL_MSB:`PLR_CTRL_IVL_LSB];
  wire run_cmd = i_forward_run_cmd | i_reverse_run_cmd;
  wire adj_open = (state_r != ST_RAMP) && (state_r != ST_COAST); // held target must not move

  // clamp interval into its legal span
  wire [4:0] ivl_s = (ivl_raw < 5'd2) ? 5'd2 : ((ivl_raw > 5'd20) ? 5'd20 : ivl_raw);

  // ------------------------------------------------------------
  // fault classification
  // ------------------------------------------------------------
  // eligible alarm set
  wire elig_fault = i_overvoltage_alarm | i_drive_overheat_alarm | i_board_overheat_alarm |
                    i_drive_overload_alarm | i_motor_overload_alarm |
                    (i_undervoltage & ~restart_en);
  wire retry_armed = (retry_lim != 3'h0);

  // restart permission after recovery, by command source
  function restart_ok;
    input kp;
    input hm;
    input run;
    input stop_seen;
    input hold_drop;
    begin
      if (kp) begin
        restart_ok = ~stop_seen;
      end else if (hm) begin
        restart_ok = ~hold_drop;
      end else begin
        restart_ok = run;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  wire wr_ctrl = i_wr & (i_addr == `PLR_REG_CTRL);
  wire wr_istat = i_wr & (i_addr == `PLR_REG_IRQ_STAT);
  wire wr_imask = i_wr & (i_addr == `PLR_REG_IRQ_MASK);
  // alarm reset is a self-clearing strobe, never stored
  wire alm_rst = wr_ctrl & i_wdata[`PLR_CTRL_ALM_RST_BIT];

  // control and mask storage
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_r <= `PLR_CTRL_RESET;
      irq_mask_r <= {`PLR_EV_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= {19'h0, i_wdata[12:0]};
      end
      if (wr_imask) begin
        irq_mask_r <= i_wdata[`PLR_EV_W-1:0];
      end
    end
  end

  // sticky status: set beats write-one-clear
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_stat_r <= {`PLR_EV_W{1'b0}};
    end else begin
      irq_stat_r <= (irq_stat_r & ~({`PLR_EV_W{wr_istat}} & i_wdata[`PLR_EV_W-1:0])) | ev;
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  // read data one cycle after strobe; unmapped reads zero
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      case (i_addr)
        `PLR_REG_CTRL: o_rdata <= ctrl_r;
        `PLR_REG_STAT: o_rdata <= {23'h0, o_any_alarm, o_link_voltage_ok_flag, state_r};
        `PLR_REG_IRQ_STAT: o_rdata <= {{(32-`PLR_EV_W){1'b0}}, irq_stat_r};
        `PLR_REG_IRQ_MASK: o_rdata <= {{(32-`PLR_EV_W){1'b0}}, irq_mask_r};
        `PLR_REG_SPEED: o_rdata <= {{(32-SPD_W){1'b0}}, held_speed_r};
        `PLR_REG_RETRY: o_rdata <= {29'h0, retry_cnt_r};
        default: o_rdata <= 32'h0;
      endcase
    end else begin
      o_rdata <= 32'h0;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // one fsm owns the output stage so faults and power loss cannot race
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_r <= ST_LOCK;
      held_speed_r <= {SPD_W{1'b0}};
      retry_cnt_r <= 3'h0;
      sec_cnt_r <= 5'h0;
      tick_cnt_r <= 32'h0;
      settle_cnt_r <= 32'h0;
      stop_seen_r <= 1'b0;
      hold_drop_r <= 1'b0;
      run_drop_r <= 1'b0;
      o_output_enable <= 1'b0;
      o_speed_cmd <= {SPD_W{1'b0}};
      o_ramp_rate <= {SPD_W{1'b0}};
      o_decel_stop <= 1'b0;
      o_undervoltage_alarm <= 1'b0;
      o_any_alarm <= 1'b0;
      o_protect_clear <= 1'b0;
      ev <= {`PLR_EV_W{1'b0}};
    end else begin
      ev <= {`PLR_EV_W{1'b0}};
      o_protect_clear <= 1'b0;
      case (state_r)
        ST_RUN: begin
          o_output_enable <= 1'b1;
          o_decel_stop <= 1'b0;
          o_speed_cmd <= adj_mode ? i_adjuster_speed : i_speed_setting;
          if (retry_cnt_r != 3'h0) begin
            if (settle_cnt_r >= SETTLE_CYCLES - 1) begin
              retry_cnt_r <= 3'h0;
              settle_cnt_r <= 32'h0;
            end else begin
              settle_cnt_r <= settle_cnt_r + 32'h1;
            end
          end
          if (i_other_fault || (elig_fault && !retry_armed)) begin
            state_r <= ST_ALARM;
            o_output_enable <= 1'b0;
            o_any_alarm <= 1'b1;
            o_undervoltage_alarm <= i_undervoltage;
            ev[`PLR_EV_ALARM] <= 1'b1;
          end else if (elig_fault) begin
            o_output_enable <= 1'b0;
            ev[`PLR_EV_TRIP] <= 1'b1;
            settle_cnt_r <= 32'h0;
            sec_cnt_r <= 5'h0;
            tick_cnt_r <= 32'h0;
            if (retry_cnt_r >= retry_lim) begin
              state_r <= ST_ALARM;
              o_any_alarm <= 1'b1;
              o_undervoltage_alarm <= i_undervoltage;
              ev[`PLR_EV_ALARM] <= 1'b1;
            end else begin
              state_r <= ST_WAIT;
            end
          end else if (i_undervoltage && restart_en) begin
            state_r <= ST_COAST;
            o_output_enable <= 1'b0;
            held_speed_r <= o_speed_cmd;
            stop_seen_r <= 1'b0;
            hold_drop_r <= 1'b0;
            run_drop_r <= 1'b0;
            ev[`PLR_EV_PFAIL] <= 1'b1;
          end else if (!keypad_mode && (hold_mode ? !i_run_hold_input : !run_cmd)) begin
            state_r <= ST_STOP;
          end
        end
        ST_COAST: begin
          o_output_enable <= 1'b0;
          if (i_keypad_stop) begin
            stop_seen_r <= 1'b1;
          end
          if (!i_run_hold_input) begin
            hold_drop_r <= 1'b1;
          end
          if (!run_cmd) begin
            run_drop_r <= 1'b1;
          end
          // recovery when link no longer undervoltage
          if (!i_undervoltage) begin
            ev[`PLR_EV_RECOVER] <= 1'b1;
            // control power loss needs fresh run in keypad or run-hold mode
            if (i_ctrl_power_lost && (keypad_mode || hold_mode)) begin
              state_r <= ST_LOCK;
            end else if (run_drop_r && !keypad_mode && !hold_mode) begin
              state_r <= ST_STOP;
              o_output_enable <= 1'b1;
              o_speed_cmd <= i_motor_speed;
            // terminal run must be on now
            end else if (restart_ok(keypad_mode, hold_mode, run_cmd, stop_seen_r,
                                    hold_drop_r)) begin
              state_r <= ST_RAMP;
              o_output_enable <= 1'b1;
              o_speed_cmd <= i_motor_speed;
              o_ramp_rate <= (held_speed_r > i_motor_speed) ?
                             ((held_speed_r - i_motor_speed) >> 4) | {{(SPD_W-1){1'b0}}, 1'b1} :
                             ((i_motor_speed - held_speed_r) >> 4) | {{(SPD_W-1){1'b0}}, 1'b1};
            end else begin
              state_r <= ST_LOCK;
            end
          end
        end
        ST_RAMP: begin
          if (i_undervoltage) begin
            state_r <= ST_COAST;
            o_output_enable <= 1'b0;
          end else if (o_speed_cmd < held_speed_r) begin
            o_speed_cmd <= (held_speed_r - o_speed_cmd > o_ramp_rate) ?
                           o_speed_cmd + o_ramp_rate : held_speed_r;
          end else if (o_speed_cmd > held_speed_r) begin
            o_speed_cmd <= (o_speed_cmd - held_speed_r > o_ramp_rate) ?
                           o_speed_cmd - o_ramp_rate : held_speed_r;
          end else begin
            state_r <= ST_RUN;
          end
        end
        ST_STOP: begin
          o_decel_stop <= 1'b1;
          o_speed_cmd <= {SPD_W{1'b0}};
          if (i_undervoltage || (i_motor_speed == {SPD_W{1'b0}})) begin
            o_output_enable <= 1'b0;
            o_decel_stop <= 1'b0;
            state_r <= ST_LOCK;
          end
        end
        ST_WAIT: begin
          o_output_enable <= 1'b0;
          if (tick_cnt_r >= SEC_CYCLES - 1) begin
            tick_cnt_r <= 32'h0;
            sec_cnt_r <= sec_cnt_r + 5'h1;
          end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
          end
          if (sec_cnt_r >= ivl_s) begin
            o_protect_clear <= 1'b1;
            retry_cnt_r <= retry_cnt_r + 3'h1;
            ev[`PLR_EV_RETRY] <= 1'b1;
            state_r <= ST_RUN;
          end
        end
        ST_ALARM: begin
          o_output_enable <= 1'b0;
          if (alm_rst) begin
            o_any_alarm <= 1'b0;
            o_undervoltage_alarm <= 1'b0;
            retry_cnt_r <= 3'h0;
            o_protect_clear <= 1'b1;
            state_r <= ST_LOCK;
          end
        end
        ST_LOCK: begin
          // fresh run command starts the drive
          o_output_enable <= 1'b0;
          o_decel_stop <= 1'b0;
          if (!i_undervoltage && (run_cmd || (keypad_mode && !i_keypad_stop && run_cmd))) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_LOCK;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // adjuster gating and link flag
  // ------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_adjuster_enable <= 1'b0;
      o_adjuster_increase <= 1'b0;
      o_adjuster_decrease <= 1'b0;
      o_adjuster_clear <= 1'b0;
      o_link_voltage_ok_flag <= 1'b0;
    end else begin
      o_adjuster_enable <= adj_open;
      o_adjuster_increase <= i_adjuster_increase_cmd && adj_open;
      o_adjuster_decrease <= i_adjuster_decrease_cmd && adj_open;
      o_adjuster_clear <= i_adjuster_clear_cmd && adj_open;
      o_link_voltage_ok_flag <= ~i_undervoltage;
    end
  end

endmodule
`default_nettype wire

/* rtl/plr_defs.vh */
`ifndef PLR_DEFS_VH
`define PLR_DEFS_VH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define PLR_ADDR_W 8
`define PLR_REG_CTRL 8'h00
`define PLR_REG_STAT 8'h04
`define PLR_REG_IRQ_STAT 8'h08
`define PLR_REG_IRQ_MASK 8'h0c
`define PLR_REG_SPEED 8'h10
`define PLR_REG_RETRY 8'h14
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define PLR_CTRL_RESTART_BIT 0
`define PLR_CTRL_ADJ_MODE_BIT 1
`define PLR_CTRL_KEYPAD_BIT 2
`define PLR_CTRL_HOLD_BIT 3
`define PLR_CTRL_RCNT_LSB 4
`define PLR_CTRL_RCNT_MSB 6
`define PLR_CTRL_IVL_LSB 8
`define PLR_CTRL_IVL_MSB 12
`define PLR_CTRL_ALM_RST_BIT 16
`define PLR_CTRL_RESET 32'h0000_0200
// ------------------------------------------------------------
// interrupt event bits
// ------------------------------------------------------------
`define PLR_EV_PFAIL 0
`define PLR_EV_RECOVER 1
`define PLR_EV_TRIP 2
`define PLR_EV_RETRY 3
`define PLR_EV_ALARM 4
`define PLR_EV_W 5
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PLR_CLK_HZ 250000000
`define PLR_SEC_CYCLES 250000000
`define PLR_IVL_MIN_S 2
`define PLR_IVL_MAX_S 20
`define PLR_SETTLE_MS 100
`define PLR_SETTLE_CYCLES (`PLR_CLK_HZ / 1000 * `PLR_SETTLE_MS)
`endif

/* bench/plr_drive_model.sv */
`default_nettype none
// ------
// far side: power stage, dc link and fault sensors
// ------
module plr_drive_model (
  input wire logic i_sys_clk,
  input wire logic i_fail,            // supply dip request
  input wire logic [2:0] i_fault,     // 0 none, 1-5 eligible, 6 other
  input wire logic i_output_enable,
  input wire logic [15:0] i_speed_cmd,
  output logic o_undervoltage,
  output logic [5:0] o_faults,
  output logic [15:0] o_motor_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet start
  initial begin
    o_undervoltage = 1'b0;
    o_faults = 6'h00;
    o_motor_speed = 16'h0000;
  end
  // sensors lag one cycle, as a real comparator would
  // link level sensed
  always @(posedge i_sys_clk) begin
    o_undervoltage <= i_fail;
    o_faults <= 6'h00;
    if (i_fault != 3'h0) begin
      o_faults[i_fault - 3'h1] <= 1'b1;
    end
  end
  // motor follows when driven; coasts down fast so a ramp is visible
  // coast when gated
  always @(posedge i_sys_clk) begin
    if (i_output_enable) begin
      o_motor_speed <= i_speed_cmd;
    end else if (o_motor_speed != 16'h0000) begin
      o_motor_speed <= o_motor_speed - (o_motor_speed >> 4) - 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* bench/plr_restart_monitor.sv */
`default_nettype none
module plr_restart_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_undervoltage,
  input wire logic i_adjuster_increase_cmd,
  input wire logic o_output_enable,
  input wire logic o_adjuster_enable,
  input wire logic o_adjuster_increase,
  input wire logic o_adjuster_decrease,
  input wire logic o_adjuster_clear,
  input wire logic o_undervoltage_alarm,
  input wire logic o_any_alarm,
  input wire logic o_link_voltage_ok_flag,
  input wire logic o_protect_clear
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // ------
  // named steps
  // ------
  // link low for three samples, sensor lag included
  sequence s_uv_held;
    i_undervoltage [*3];
  endsequence
  // command seen while adjuster path open
  sequence s_adj_cmd;
    i_adjuster_increase_cmd ##1 o_adjuster_enable;
  endsequence
  // ------
  // checks
  // ------
  a_link_flag_follow: assert property (!$past(i_rst) |->
    o_link_voltage_ok_flag == !$past(i_undervoltage)) else $error("link flag wrong");
  a_uv_cuts_output: assert property (s_uv_held |-> !o_output_enable)
    else $error("output on at undervoltage");
  a_alarm_gates_output: assert property (o_any_alarm |-> !o_output_enable)
    else $error("output on in alarm");
  a_uv_alarm_mode: assert property (o_undervoltage_alarm |-> o_any_alarm)
    else $error("uv alarm outside alarm mode");
  a_adj_gated_ramp: assert property (!o_adjuster_enable |->
    !(o_adjuster_increase || o_adjuster_decrease || o_adjuster_clear))
    else $error("adjuster cmd leaked");
  a_adj_passes_run: assert property (s_adj_cmd |-> o_adjuster_increase)
    else $error("adjuster cmd dropped");
  a_adj_no_phantom: assert property (o_adjuster_increase |->
    $past(i_adjuster_increase_cmd)) else $error("adjuster cmd invented");
  a_clear_one_cycle: assert property (o_protect_clear |=> !o_protect_clear)
    else $error("clear pulse too long");
  a_clear_after_gate: assert property (o_protect_clear |->
    !$past(o_output_enable) && !$past(o_output_enable, 2)) else $error("clear while on");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside slot");
endmodule
bind plr_restart plr_restart_monitor u_plr_restart_monitor (.i_sys_clk, .i_rst, .i_rd,
  .o_rdata, .i_undervoltage, .i_adjuster_increase_cmd, .o_output_enable,
  .o_adjuster_enable, .o_adjuster_increase, .o_adjuster_decrease, .o_adjuster_clear,
  .o_undervoltage_alarm, .o_any_alarm, .o_link_voltage_ok_flag, .o_protect_clear);
`default_nettype wire

/* bench/testbench.sv */
`include "plr_defs.vh"
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("FAIL %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // stimulus and observed signals
  // ------
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, e;
  logic fail = 1'b0, i_ctrl_power_lost = 1'b0, i_forward_run_cmd = 1'b0;
  logic i_reverse_run_cmd = 1'b0, i_keypad_stop = 1'b0, i_run_hold_input = 1'b1;
  logic [2:0] adj = 3'h0, adj_o, fault = 3'h0;
  logic [5:0] flt;
  logic [15:0] i_motor_speed, i_speed_setting = 16'h0, i_adjuster_speed = 16'h0;
  logic [15:0] o_speed_cmd, tgt, rate;
  logic i_undervoltage, o_output_enable, o_decel_stop, o_undervoltage_alarm;
  logic o_any_alarm, o_protect_clear, o_irq;
  logic [31:0] exp_q[$];  // read notes, oldest first
  string nm_q[$];
  string n;
  int err_count = 0, checks_done = 0, cnt;
  // run-command cases: exp, lost, hold drop, stop key
  logic [3:0] cs[5] = '{4'h1, 4'h4, 4'h8, 4'h2, 4'h8};
  logic [31:0] ctl[5] = '{32'h205, 32'h205, 32'h205, 32'h209, 32'h209};
  plr_drive_model u_plr_drive_model (.i_sys_clk, .i_fail(fail), .i_fault(fault),
    .i_output_enable(o_output_enable), .i_speed_cmd(o_speed_cmd),
    .o_undervoltage(i_undervoltage), .o_faults(flt), .o_motor_speed(i_motor_speed));
  plr_restart #(.SEC_CYCLES(10), .SETTLE_CYCLES(20)) u_plr_restart (.i_sys_clk, .i_rst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_undervoltage, .i_ctrl_power_lost,
    .i_overvoltage_alarm(flt[0]), .i_drive_overheat_alarm(flt[1]),
    .i_board_overheat_alarm(flt[2]), .i_drive_overload_alarm(flt[3]),
    .i_motor_overload_alarm(flt[4]), .i_other_fault(flt[5]), .i_forward_run_cmd,
    .i_reverse_run_cmd, .i_keypad_stop, .i_run_hold_input,
    .i_adjuster_increase_cmd(adj[0]), .i_adjuster_decrease_cmd(adj[1]),
    .i_adjuster_clear_cmd(adj[2]), .i_motor_speed, .i_speed_setting, .i_adjuster_speed,
    .o_output_enable, .o_speed_cmd, .o_ramp_rate(rate), .o_decel_stop, .o_adjuster_enable(),
    .o_adjuster_increase(adj_o[0]), .o_adjuster_decrease(adj_o[1]),
    .o_adjuster_clear(adj_o[2]), .o_undervoltage_alarm, .o_any_alarm,
    .o_link_voltage_ok_flag(), .o_protect_clear, .o_irq);
  always #2 i_sys_clk = ~i_sys_clk;
  // ------
  // read checker: data stands only in the slot after the strobe
  // ------
  always @(posedge i_sys_clk) begin
    rd_d <= i_rd;
    if (rd_d) begin
      e = exp_q.pop_front();
      n = nm_q.pop_front();
      `CHK(n, e, o_rdata)
    end
  end
  // ------
  // bus and sequence tasks
  // ------
  task automatic cyc(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(x);
    nm_q.push_back(s);
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
  endtask
  // fresh reset, program control, start running
  task automatic cfg(input logic [31:0] c);
    i_rst <= 1'b1;
    i_forward_run_cmd <= 1'b0;
    cyc(8);
    i_rst <= 1'b0;
    wr(`PLR_REG_CTRL, c);
    i_forward_run_cmd <= 1'b1;
    for (int k = 0; k < 50 && o_output_enable !== 1'b1; k++) @(posedge i_sys_clk);
    `CHK("run", 1'b1, o_output_enable)
  endtask
  // hold a fault (bit 3: supply dip) until alarm, counting retries
  task automatic run_fault(input logic [3:0] f, input int np);
    cnt = 0;
    fault <= f[2:0];
    fail <= f[3];
    for (int k = 0; k < 600 && o_any_alarm !== 1'b1; k++) begin
      @(posedge i_sys_clk);
      cnt += int'(o_protect_clear === 1'b1);
    end
    `CHK("retries", np, cnt)
    `CHK("alarm", 1'b1, o_any_alarm)
    fault <= 3'h0;
    fail <= 1'b0;
  endtask
  task automatic wait_spd;
    for (int k = 0; k < 1000 && o_speed_cmd !== tgt; k++) @(posedge i_sys_clk);
  endtask
  // ------
  // closing
  // ------
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog, well beyond the thousand or so cycles the run needs
  initial begin
    cyc(30000);
    err_count++;
    stop_test();
  end
  // ------
  // main sequence
  // ------
  initial begin
    void'($urandom(32'h4675e1de));
    cyc(8);
    i_rst <= 1'b0;
    rd(`PLR_REG_CTRL, `PLR_CTRL_RESET, "ctrl");
    rd(`PLR_REG_STAT, 32'hc0, "stat");
    rd(8'h20, 32'h0, "unmapped");
    rd(`PLR_REG_RETRY, 32'h0, "retry");
    // each eligible alarm: short fault, timed retry, clean run
    cfg(32'h221);
    for (int k = 1; k <= 5; k++) begin
      cnt = 0;
      fault <= 3'(k);
      cyc(3);
      fault <= 3'h0;
      while (o_protect_clear !== 1'b1 && cnt < 200) begin
        @(posedge i_sys_clk);
        cnt++;
      end
      `CHK("interval", 1'b1, cnt >= 20 && cnt <= 30)
      cyc(3);
      `CHK("oe", 1'b1, o_output_enable)
      `CHK("no alarm", 1'b0, o_any_alarm)
      rd(`PLR_REG_RETRY, 32'h1, "retry");
      cyc(30);
      rd(`PLR_REG_RETRY, 32'h0, "retry");
    end
    // persistent fault exhausts two retries; interrupt and alarm reset
    cfg(32'h221);
    wr(`PLR_REG_IRQ_MASK, 32'h10);
    run_fault(4'h3, 2);
    cyc(2);
    `CHK("irq", 1'b1, o_irq)
    rd(`PLR_REG_STAT, 32'h1a0, "stat");
    wr(`PLR_REG_IRQ_MASK, 32'h0);
    cyc(1);
    `CHK("irq", 1'b0, o_irq)
    wr(`PLR_REG_IRQ_STAT, 32'h1f);
    wr(`PLR_REG_IRQ_MASK, 32'h10);
    cyc(1);
    `CHK("irq", 1'b0, o_irq)
    wr(`PLR_REG_CTRL, 32'h10221);
    cyc(4);
    `CHK("alarm reset", 1'b0, o_any_alarm)
    rd(`PLR_REG_RETRY, 32'h0, "retry");
    // ineligible fault, zero retries, mode 0 dip
    cfg(32'h221);
    run_fault(4'h6, 0);
    cfg(32'h201);
    run_fault(4'h1, 0);
    cfg(32'h200);
    run_fault(4'h8, 0);
    `CHK("uv alarm", 1'b1, o_undervoltage_alarm)
    cyc(30);
    `CHK("no restart", 1'b0, o_output_enable)
    // restart ramp, ramp mode then adjuster mode
    for (int m = 0; m < 2; m++) begin
      i_speed_setting <= 16'h0800 + 16'($urandom_range(28672));
      i_adjuster_speed <= 16'h0800 + 16'($urandom_range(28672));
      cfg(32'h201 | 32'(m << 1));
      tgt = m ? i_adjuster_speed : i_speed_setting;
      wait_spd();
      fail <= 1'b1;
      cyc(6);
      `CHK("coast", 1'b0, o_output_enable)
      `CHK("uv alarm", 1'b0, o_undervoltage_alarm)
      rd(`PLR_REG_SPEED, 32'(tgt), "held");
      cyc(40);
      adj <= 3'h7;
      fail <= 1'b0;
      cyc(6);
      `CHK("adj blocked", 3'h0, adj_o)
      rd(`PLR_REG_STAT, 32'h84, "ramp");
      `CHK("rate", 1'b1, rate != 16'h0)
      wait_spd();
      `CHK("speed", tgt, o_speed_cmd)
      cyc(3);
      `CHK("adj open", 3'h7, adj_o)
      adj <= 3'h0;
    end
    // run commands withdrawn in the dip
    cfg(32'h201);
    fail <= 1'b1;
    cyc(4);
    i_forward_run_cmd <= 1'b0;
    cyc(4);
    fail <= 1'b0;
    for (int k = 0; k < 30 && o_decel_stop !== 1'b1; k++) @(posedge i_sys_clk);
    `CHK("decel", 1'b1, o_decel_stop)
    // keypad and run-hold restart conditions
    for (int c = 0; c < 5; c++) begin
      cfg(ctl[c]);
      i_forward_run_cmd <= 1'b0;
      fail <= 1'b1;
      cyc(4);
      i_keypad_stop <= cs[c][0];
      i_run_hold_input <= !cs[c][1];
      i_ctrl_power_lost <= cs[c][2];
      cyc(4);
      i_keypad_stop <= 1'b0;
      i_run_hold_input <= 1'b1;
      fail <= 1'b0;
      cyc(40);
      i_ctrl_power_lost <= 1'b0;
      `CHK("restart", cs[c][3], o_output_enable && !o_decel_stop)
    end
    cyc(4);
    stop_test();
  end
endmodule
`default_nettype wire
